// ==== inc/rlenc_cfg.svh ====
// rlenc_cfg.svh: offsets, field positions and timing counts of the return-link encoder.
// assumes inclusion by the package and the design files, by its bare name.
`ifndef RLENC_CFG_SVH
`define RLENC_CFG_SVH

// ----------------------------------------------------------------------------
// configuration word fields
// ----------------------------------------------------------------------------
`define RLENC_RACING_BIRD_BIT  25

// ----------------------------------------------------------------------------
// carrier periods per bit
// ----------------------------------------------------------------------------
`define RLENC_RF8   7'h08
`define RLENC_RF16  7'h10
`define RLENC_RF32  7'h20
`define RLENC_RF40  7'h28
`define RLENC_RF64  7'h40

// ----------------------------------------------------------------------------
// preset word addresses and lengths
// ----------------------------------------------------------------------------
`define RLENC_PRESET_FIRST  4'h5
`define RLENC_RB_LAST       4'h7
`define RLENC_LS_LAST       4'h8
`define RLENC_FULL_BITS     6'h20
`define RLENC_HALF_BITS     6'h10
`define RLENC_FIFO_DEPTH    4

`endif

// ==== inc/rlenc_pkg.sv ====
// rlenc_pkg.sv: types shared by the return-link encoder files.
// assumes rlenc_cfg.svh sits on the include path.
`include "rlenc_cfg.svh"

package rlenc_pkg;

  typedef enum logic {
    RLENC_MANCHESTER = 1'b0,
    RLENC_BIPHASE    = 1'b1
  } rlenc_enc_e;

  typedef enum logic [2:0] {
    RLENC_RATE_8  = 3'b000,
    RLENC_RATE_16 = 3'b001,
    RLENC_RATE_32 = 3'b010,
    RLENC_RATE_40 = 3'b011,
    RLENC_RATE_64 = 3'b100
  } rlenc_rate_e;

  // one word queued for coding, with the coding it was fetched under
  typedef struct packed {
    logic [31:0] data;
    logic [5:0]  nbits;
    rlenc_enc_e  enc;
    rlenc_rate_e rate;
  } rlenc_word_s;

  // default-read setup, as decoded from the configuration word
  typedef struct packed {
    rlenc_enc_e  enc;
    rlenc_rate_e rate;
    logic [3:0]  first_word;
    logic [3:0]  last_word;
    logic        racing_bird_mode_bit;
    logic        livestock_mode;
  } rlenc_setup_s;

  typedef enum logic [1:0] {
    RLENC_SQ_IDLE = 2'b00,
    RLENC_SQ_REQ  = 2'b01,
    RLENC_SQ_WAIT = 2'b10
  } rlenc_seq_e;

  typedef enum logic {
    RLENC_EN_IDLE = 1'b0,
    RLENC_EN_RUN  = 1'b1
  } rlenc_enst_e;

endpackage

// ==== rtl/rlenc_fifo.sv ====
// rlenc_fifo.sv: small valid/ready FIFO between memory fetch and the coder.
// assumes a single clock and synchronous active-high reset.
`timescale 1ns/1ps

module rlenc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    nxt_wr;
  logic [AW-1:0]    rd_ff;
  logic [AW-1:0]    nxt_rd;
  logic [AW:0]      cnt_ff;
  logic [AW:0]      nxt_cnt;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rd_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    nxt_wr  = push ? ((wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1) : wr_ff;
    nxt_rd  = pop ? ((rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1) : rd_ff;
    nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  // storage needs no reset: entries are only read once counted valid
  always_ff @(posedge clock) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

endmodule // rlenc_fifo

// ==== rtl/rlenc_encoder.sv ====
// rlenc_encoder.sv: return-link encoder; fetches memory words, codes them
// Manchester or Bi-phase and drives the load modulator.
// assumes carrier_tick is one clock-wide per field period, synchronous to clock,
// and the memory answers each read request with exactly one mem_rvalid pulse.
`timescale 1ns/1ps
`include "rlenc_cfg.svh"

module rlenc_encoder (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst,
  // field carrier
  input  wire logic                   carrier_tick,
  // setup and read control
  input  wire rlenc_pkg::rlenc_setup_s setup,
  input  wire logic                   read_enable,
  input  wire logic                   cmd_read_valid,
  input  wire logic [3:0]             cmd_read_addr,
  output logic                        cmd_read_ready,
  // memory read port
  output logic                        mem_req,
  output logic [3:0]                  mem_addr,
  input  wire logic                   mem_rvalid,
  input  wire logic [31:0]            mem_rdata,
  // modulator
  output logic                        mod_on,
  output logic                        busy
);

  import rlenc_pkg::*;

  // --------------------------------------------------------------------------
  // effective setup
  // --------------------------------------------------------------------------
  rlenc_enc_e  eff_enc;
  rlenc_rate_e eff_rate;
  logic [3:0]  eff_first;
  logic [3:0]  eff_last;

  always_comb begin
    eff_enc   = setup.enc;
    eff_rate  = setup.rate;
    eff_first = setup.first_word;
    eff_last  = setup.last_word;
    if (setup.racing_bird_mode_bit) begin
      eff_enc   = RLENC_MANCHESTER;
      eff_rate  = RLENC_RATE_64;
      eff_first = `RLENC_PRESET_FIRST;
      eff_last  = `RLENC_RB_LAST;
    end else if (setup.livestock_mode) begin
      eff_enc   = RLENC_BIPHASE;
      eff_rate  = RLENC_RATE_32;
      eff_first = `RLENC_PRESET_FIRST;
      eff_last  = `RLENC_LS_LAST;
    end
  end

  // --------------------------------------------------------------------------
  // word fetch sequencer
  // --------------------------------------------------------------------------
  rlenc_seq_e  sq_ff;
  rlenc_seq_e  nxt_sq;
  logic [3:0]  addr_ff;
  logic [3:0]  nxt_addr;
  logic        single_ff;
  logic        nxt_single;
  logic        rb_ff;
  logic        nxt_rb;
  rlenc_enc_e  wenc_ff;
  rlenc_enc_e  nxt_wenc;
  rlenc_rate_e wrate_ff;
  rlenc_rate_e nxt_wrate;
  logic        fifo_in_ready;
  rlenc_word_s fifo_in;

  assign cmd_read_ready = (sq_ff == RLENC_SQ_IDLE);
  assign mem_req        = (sq_ff == RLENC_SQ_REQ) && fifo_in_ready;
  assign mem_addr       = addr_ff;

  always_comb begin
    nxt_sq     = sq_ff;
    nxt_addr   = addr_ff;
    nxt_single = single_ff;
    nxt_rb     = rb_ff;
    nxt_wenc   = wenc_ff;
    nxt_wrate  = wrate_ff;
    case (sq_ff)
      RLENC_SQ_IDLE: begin
        // a word read command takes precedence over the default stream
        if (cmd_read_valid) begin
          nxt_sq     = RLENC_SQ_REQ;
          nxt_addr   = cmd_read_addr;
          nxt_single = 1'b1;
          nxt_rb     = 1'b0;
          nxt_wenc   = eff_enc;
          nxt_wrate  = eff_rate;
        end else if (read_enable) begin
          nxt_sq     = RLENC_SQ_REQ;
          nxt_addr   = eff_first;
          nxt_single = 1'b0;
          nxt_rb     = setup.racing_bird_mode_bit;
          nxt_wenc   = eff_enc;
          nxt_wrate  = eff_rate;
        end
      end
      RLENC_SQ_REQ: begin
        // full fifo stalls the fetch here
        if (fifo_in_ready) begin
          nxt_sq = RLENC_SQ_WAIT;
        end
      end
      RLENC_SQ_WAIT: begin
        if (mem_rvalid) begin
          if (single_ff || addr_ff == eff_last) begin
            // default stream loops from the first word while enabled
            nxt_sq = RLENC_SQ_IDLE;
          end else begin
            nxt_sq   = RLENC_SQ_REQ;
            nxt_addr = addr_ff + 4'h1;
          end
        end
      end
      default: nxt_sq = RLENC_SQ_IDLE;
    endcase
  end

  always_comb begin
    fifo_in.data  = mem_rdata;
    fifo_in.enc   = wenc_ff;
    fifo_in.rate  = wrate_ff;
    // words 6 and 7 contribute only their low half in racing-bird mode
    fifo_in.nbits = (rb_ff && addr_ff != `RLENC_PRESET_FIRST) ?
                    `RLENC_HALF_BITS : `RLENC_FULL_BITS;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sq_ff     <= RLENC_SQ_IDLE;
      addr_ff   <= 4'h0;
      single_ff <= 1'b0;
      rb_ff     <= 1'b0;
      wenc_ff   <= RLENC_MANCHESTER;
      wrate_ff  <= RLENC_RATE_64;
    end else begin
      sq_ff     <= nxt_sq;
      addr_ff   <= nxt_addr;
      single_ff <= nxt_single;
      rb_ff     <= nxt_rb;
      wenc_ff   <= nxt_wenc;
      wrate_ff  <= nxt_wrate;
    end
  end

  // --------------------------------------------------------------------------
  // word queue
  // --------------------------------------------------------------------------
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  rlenc_word_s fifo_out;

  // only one read is outstanding and it is issued with room, so no data drops
  rlenc_fifo #(
    .WIDTH ($bits(rlenc_word_s)),
    .DEPTH (`RLENC_FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (mem_rvalid && sq_ff == RLENC_SQ_WAIT),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out)
  );

  // --------------------------------------------------------------------------
  // bit coder
  // --------------------------------------------------------------------------
  function automatic logic [6:0] rate_periods(input rlenc_rate_e r);
    case (r)
      RLENC_RATE_8:  rate_periods = `RLENC_RF8;
      RLENC_RATE_16: rate_periods = `RLENC_RF16;
      RLENC_RATE_32: rate_periods = `RLENC_RF32;
      RLENC_RATE_40: rate_periods = `RLENC_RF40;
      RLENC_RATE_64: rate_periods = `RLENC_RF64;
      default:       rate_periods = `RLENC_RF64;
    endcase
  endfunction

  rlenc_enst_e en_ff;
  rlenc_enst_e nxt_en;
  logic [31:0] sh_ff;
  logic [31:0] nxt_sh;
  logic [5:0]  left_ff;
  logic [5:0]  nxt_left;
  logic [6:0]  cnt_ff;
  logic [6:0]  nxt_cnt;
  logic [6:0]  per_ff;
  logic [6:0]  nxt_per;
  rlenc_enc_e  enc_ff;
  rlenc_enc_e  nxt_enc;
  logic        lvl_ff;
  logic        nxt_lvl;
  logic        bit_end;
  logic        mid_bit;

  assign bit_end        = (en_ff == RLENC_EN_RUN) && carrier_tick && (cnt_ff == per_ff - 7'h01);
  assign mid_bit        = (en_ff == RLENC_EN_RUN) && carrier_tick && (cnt_ff == (per_ff >> 1) - 7'h01);
  assign fifo_out_ready = (en_ff == RLENC_EN_IDLE) || (bit_end && left_ff == 6'h01);
  assign mod_on         = lvl_ff;
  assign busy           = (en_ff == RLENC_EN_RUN);

  always_comb begin
    nxt_en   = en_ff;
    nxt_sh   = sh_ff;
    nxt_left = left_ff;
    nxt_per  = per_ff;
    nxt_enc  = enc_ff;
    nxt_lvl  = lvl_ff;
    nxt_cnt  = (en_ff == RLENC_EN_RUN && carrier_tick) ? cnt_ff + 7'h01 : cnt_ff;
    if (fifo_out_valid && fifo_out_ready) begin
      // new word: first bit starts now, lsb first
      nxt_en   = RLENC_EN_RUN;
      nxt_sh   = fifo_out.data;
      nxt_left = fifo_out.nbits;
      nxt_per  = rate_periods(fifo_out.rate);
      nxt_enc  = fifo_out.enc;
      nxt_cnt  = 7'h00;
      if (fifo_out.enc == RLENC_MANCHESTER) begin
        nxt_lvl = fifo_out.data[0];
      end else begin
        nxt_lvl = ~lvl_ff;
      end
    end else if (bit_end) begin
      nxt_cnt = 7'h00;
      if (left_ff == 6'h01) begin
        // starved: load released so the reader sees no stray edges
        nxt_en  = RLENC_EN_IDLE;
        nxt_lvl = 1'b0;
      end else begin
        nxt_sh   = {1'b0, sh_ff[31:1]};
        nxt_left = left_ff - 6'h01;
        if (enc_ff == RLENC_MANCHESTER) begin
          nxt_lvl = sh_ff[1];
        end else begin
          nxt_lvl = ~lvl_ff;
        end
      end
    end else if (mid_bit) begin
      if (enc_ff == RLENC_MANCHESTER) begin
        nxt_lvl = ~sh_ff[0];
      end else if (!sh_ff[0]) begin
        nxt_lvl = ~lvl_ff;
      end else begin
        nxt_lvl = lvl_ff;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      en_ff   <= RLENC_EN_IDLE;
      sh_ff   <= 32'h0000_0000;
      left_ff <= 6'h00;
      cnt_ff  <= 7'h00;
      per_ff  <= `RLENC_RF64;
      enc_ff  <= RLENC_MANCHESTER;
      lvl_ff  <= 1'b0;
    end else begin
      en_ff   <= nxt_en;
      sh_ff   <= nxt_sh;
      left_ff <= nxt_left;
      cnt_ff  <= nxt_cnt;
      per_ff  <= nxt_per;
      enc_ff  <= nxt_enc;
      lvl_ff  <= nxt_lvl;
    end
  end

endmodule // rlenc_encoder

// ==== tb/rlenc_encoder_monitor.sv ====
// rlenc_encoder_monitor.sv: port assertions of the return-link encoder.
// assumes rlenc_pkg is compiled first; bound into rlenc_encoder below.
`timescale 1ns/1ps

module rlenc_encoder_monitor (
  // clock and reset
  input wire logic                   clock,
  input wire logic                   rst,
  // control inputs
  input wire logic                   carrier_tick,
  input wire rlenc_pkg::rlenc_setup_s setup,
  input wire logic                   read_enable,
  input wire logic                   cmd_read_valid,
  input wire logic [3:0]             cmd_read_addr,
  input wire logic                   cmd_read_ready,
  // memory and modulator
  input wire logic                   mem_req,
  input wire logic [3:0]             mem_addr,
  input wire logic                   mem_rvalid,
  input wire logic [31:0]            mem_rdata,
  input wire logic                   mod_on,
  input wire logic                   busy
);
  import rlenc_pkg::*;
  // --------------------------------------------------------------------------
  // ticks since the last level change
  // --------------------------------------------------------------------------
  logic [7:0] gap_ff, nxt_gap, per;
  logic       mod_q_ff, nxt_mod_q;
  always_comb begin
    nxt_mod_q = mod_on;
    nxt_gap = gap_ff + {7'h00, carrier_tick};
    if (mod_on != mod_q_ff) nxt_gap = {7'h00, carrier_tick};
    // a tick on the word's load edge is not part of its first bit
    if (!busy) nxt_gap = 8'h00;
    case (setup.rate)
      RLENC_RATE_8:  per = 8'h08;
      RLENC_RATE_16: per = 8'h10;
      RLENC_RATE_32: per = 8'h20;
      RLENC_RATE_40: per = 8'h28;
      default:       per = 8'h40;
    endcase
    // presets override the plain rate
    if (setup.livestock_mode) per = 8'h20;
    if (setup.racing_bird_mode_bit) per = 8'h40;
  end
  always_ff @(posedge clock) begin
    gap_ff <= rst ? 8'h00 : nxt_gap;
    mod_q_ff <= rst ? 1'b0 : nxt_mod_q;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  reset_quiet_a: assert property (disable iff (1'b0) rst |=> !mod_on && !busy && !mem_req && cmd_read_ready)
    else $error("outputs not quiet after reset");
  idle_low_a: assert property (!busy && $past(!busy) |-> !mod_on)
    else $error("modulator on while idle");
  req_single_a: assert property (mem_req |=> !mem_req && !cmd_read_ready)
    else $error("second request while one outstanding");
  cmd_fetch_a: assert property (cmd_read_valid && cmd_read_ready |=> mem_req && mem_addr == $past(cmd_read_addr))
    else $error("command word not fetched");
  tick_change_a: assert property ($changed(mod_on) && busy && $past(busy) |-> $past(carrier_tick))
    else $error("level change not on a carrier tick");
  gap_min_a: assert property ($changed(mod_on) && busy && $past(busy) |-> gap_ff >= {1'b0, per[7:1]})
    else $error("level held shorter than half a bit");
  gap_max_a: assert property (busy && $past(busy) |-> gap_ff <= per)
    else $error("level held longer than a bit");
  gap_exact_a: assert property ($changed(mod_on) && busy && $past(busy)
    |-> gap_ff == {1'b0, per[7:1]} || gap_ff == per)
    else $error("level change off a half-bit boundary");
  rb_addr_a: assert property (mem_req && read_enable && setup.racing_bird_mode_bit |-> mem_addr inside {[4'h5:4'h7]})
    else $error("racing-bird fetch outside words 5 to 7");
  ls_addr_a: assert property (mem_req && read_enable && setup.livestock_mode && !setup.racing_bird_mode_bit
    |-> mem_addr inside {[4'h5:4'h8]})
    else $error("livestock fetch outside words 5 to 8");
  cover property (cmd_read_valid && cmd_read_ready);
  cover property (mem_req && setup.racing_bird_mode_bit);
  cover property (mem_req && setup.livestock_mode);
endmodule // rlenc_encoder_monitor

bind rlenc_encoder rlenc_encoder_monitor u_monitor (
  .clock(clock), .rst(rst), .carrier_tick(carrier_tick), .setup(setup), .read_enable(read_enable),
  .cmd_read_valid(cmd_read_valid), .cmd_read_addr(cmd_read_addr), .cmd_read_ready(cmd_read_ready),
  .mem_req(mem_req), .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
  .mod_on(mod_on), .busy(busy));

// ==== tb/rlenc_mem_model.sv ====
// rlenc_mem_model.sv: word memory answering the encoder's read port.
// assumes one request outstanding; latency set by the bench.
`timescale 1ns/1ps

module rlenc_mem_model (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // read port
  input wire logic        mem_req,
  input wire logic [3:0]  mem_addr,
  input wire logic [3:0]  lat,
  output logic            mem_rvalid,
  output logic     [31:0] mem_rdata
);
  logic [31:0] words [16];
  logic [3:0]  cnt_ff;
  logic [3:0]  addr_ff;
  logic        pend_ff;
  always @(posedge clock) begin
    mem_rvalid <= 1'b0;
    // bus toggles when not valid, so stale data never looks right
    mem_rdata <= ~mem_rdata;
    if (rst) begin
      pend_ff <= 1'b0;
      mem_rdata <= 32'h0000_0000;
    end else if (mem_req) begin
      pend_ff <= 1'b1;
      cnt_ff <= lat;
      addr_ff <= mem_addr;
    end else if (pend_ff && cnt_ff == 4'h0) begin
      pend_ff <= 1'b0;
      mem_rvalid <= 1'b1;
      mem_rdata <= words[addr_ff];
    end else if (pend_ff) begin
      cnt_ff <= cnt_ff - 4'h1;
    end
  end
endmodule // rlenc_mem_model

// ==== tb/testbench.sv ====
// testbench.sv: random and corner word reads, both presets, mid-run reset.
// assumes rlenc_pkg, the design, the memory model and the monitor compiled.
`timescale 1ns/1ps

module testbench;
  import rlenc_pkg::*;
  // --------------------------------------------------------------------------
  // stimulus and instances
  // --------------------------------------------------------------------------
  logic         clock = 1'b0;
  logic         rst = 1'b1;
  logic         carrier_tick = 1'b0;
  rlenc_setup_s setup = '0;
  logic         read_enable = 1'b0;
  logic         cmd_read_valid = 1'b0;
  logic [3:0]   cmd_read_addr = 4'h0;
  logic [3:0]   lat = 4'h0;
  logic [1:0]   div = 2'h0;
  logic [31:0]  seed = 32'hfec0_f890;
  logic         cmd_read_ready, mem_req, mem_rvalid, mod_on, busy;
  logic [3:0]   mem_addr;
  logic [31:0]  mem_rdata;
  int           failures = 0;
  int           samples_checked = 0;
  always #2 clock = ~clock;
  always @(posedge clock) begin
    div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
    carrier_tick <= (div == 2'h2);
  end
  rlenc_encoder u_dut (.clock(clock), .rst(rst), .carrier_tick(carrier_tick), .setup(setup),
    .read_enable(read_enable), .cmd_read_valid(cmd_read_valid), .cmd_read_addr(cmd_read_addr),
    .cmd_read_ready(cmd_read_ready), .mem_req(mem_req), .mem_addr(mem_addr), .mem_rvalid(mem_rvalid),
    .mem_rdata(mem_rdata), .mod_on(mod_on), .busy(busy));
  rlenc_mem_model u_mem (.clock(clock), .rst(rst), .mem_req(mem_req), .mem_addr(mem_addr), .lat(lat),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
  // --------------------------------------------------------------------------
  // expectations and checks
  // --------------------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // two half-bit levels; bi-phase carries the running level
  function automatic logic [1:0] exp_pair(input rlenc_enc_e enc, input logic b, input logic lvl);
    if (enc == RLENC_MANCHESTER) return {b, ~b};
    return {~lvl, b ? ~lvl : lvl};
  endfunction
  task automatic results;
    if (failures == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic compare_level(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask
  task automatic ticks(input int n);
    int k;
    k = 0;
    while (k < n) begin
      @(posedge clock);
      if (carrier_tick) k++;
    end
  endtask
  // samples each half-bit at its middle, clear of the tick edges
  task automatic check_stream(input logic [127:0] bits, input int n, input int per, input rlenc_enc_e enc);
    int w;
    logic lvl;
    logic [1:0] e;
    lvl = 1'b0;
    w = 0;
    while (busy !== 1'b1 && w < 400) begin
      @(posedge clock);
      #1;
      w++;
    end
    if (w == 400) begin
      failures++;
      results();
    end
    ticks(per / 4);
    for (int i = 0; i < n; i++) begin
      e = exp_pair(enc, bits[i], lvl);
      lvl = e[0];
      #1;
      compare_level(mod_on, e[1], "first half level");
      ticks(per / 2);
      #1;
      compare_level(mod_on, e[0], "second half level");
      ticks(per / 2);
    end
  endtask
  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial begin
    int w;
    int pr [5];
    logic [31:0] d;
    pr = '{8, 16, 32, 40, 64};
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    for (int e = 0; e < 2; e++) begin
      for (int r = 0; r < 5; r++) begin
        seed = xorshift(seed);
        // all ones and all zeros as corners, then random words
        d = (r == 0) ? 32'hffff_ffff : (r == 1) ? 32'h0000_0000 : xorshift(seed);
        u_mem.words[seed[31:28]] = d;
        @(posedge clock);
        setup.enc <= rlenc_enc_e'(e);
        setup.rate <= rlenc_rate_e'(r);
        lat <= seed[11:8];
        cmd_read_addr <= seed[31:28];
        cmd_read_valid <= 1'b1;
        w = 0;
        do begin
          @(posedge clock);
          w++;
        end while (cmd_read_ready !== 1'b1 && w < 50);
        if (cmd_read_ready !== 1'b1) begin
          failures++;
          results();
        end
        cmd_read_valid <= 1'b0;
        check_stream({96'h0, d}, 32, pr[r], rlenc_enc_e'(e));
        compare_level(mod_on, 1'b0, "idle level");
      end
    end
    for (int i = 5; i < 9; i++) begin
      seed = xorshift(seed);
      u_mem.words[i] = seed;
    end
    @(posedge clock);
    setup <= '{RLENC_BIPHASE, RLENC_RATE_8, 4'h0, 4'h0, 1'b1, 1'b0};
    read_enable <= 1'b1;
    check_stream({64'h0, u_mem.words[7][15:0], u_mem.words[6][15:0], u_mem.words[5]}, 64, 64,
      RLENC_MANCHESTER);
    rst <= 1'b1;
    read_enable <= 1'b0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    setup <= '{RLENC_MANCHESTER, RLENC_RATE_8, 4'h0, 4'h0, 1'b0, 1'b1};
    read_enable <= 1'b1;
    check_stream({u_mem.words[8], u_mem.words[7], u_mem.words[6], u_mem.words[5]}, 128, 32,
      RLENC_BIPHASE);
    // plain default stream over a configured word range, after a second reset
    rst <= 1'b1;
    read_enable <= 1'b0;
    for (int i = 9; i < 11; i++) begin
      seed = xorshift(seed);
      u_mem.words[i] = seed;
    end
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    setup <= '{RLENC_BIPHASE, RLENC_RATE_16, 4'h9, 4'ha, 1'b0, 1'b0};
    read_enable <= 1'b1;
    check_stream({64'h0, u_mem.words[10], u_mem.words[9]}, 64, 16, RLENC_BIPHASE);
    results();
  end
endmodule // testbench
